/* File: verilog/ipc_pkg.sv */
// Purpose: Shared constants and types for the in-system programming control block
// Assumes: 8-bit special-function-register bus, 16-bit flash address
// Notes: Addresses without a fixed location are grouped here as named constants
package ipc_pkg;

  // Register addresses on the special-function-register bus
  localparam logic [7:0] IPC_ADDR_CTRL = 8'hbf;
  localparam logic [7:0] IPC_ADDR_CMD = 8'hc7;
  localparam logic [7:0] IPC_ADDR_KEY = 8'hf6;
  localparam logic [7:0] IPC_ADDR_ALO = 8'hc4;
  localparam logic [7:0] IPC_ADDR_AHI = 8'hc5;
  localparam logic [7:0] IPC_ADDR_DAT = 8'hc6;

  // Unlock key values, in the order they must arrive
  localparam logic [7:0] IPC_KEY_FIRST = 8'h87;
  localparam logic [7:0] IPC_KEY_SECOND = 8'h59;

  // Programming control register fields
  localparam int IPC_CTRL_ARM_BIT = 0;
  localparam int IPC_CTRL_LOC_BIT = 1;
  localparam int IPC_CTRL_AUX_BIT = 4;
  localparam logic [7:0] IPC_CTRL_WR_MASK = 8'h13;
  localparam logic [7:0] IPC_CTRL_SWR_MASK = 8'h83;
  localparam logic [7:0] IPC_CTRL_RESET = 8'h00;

  // Flash command byte fields
  localparam int IPC_CMD_BANK_BIT = 6;
  localparam int IPC_CMD_OE_BIT = 5;
  localparam int IPC_CMD_CE_BIT = 4;
  localparam logic [7:0] IPC_CMD_WR_MASK = 8'h7f;
  localparam logic [7:0] IPC_CMD_RESET = 8'h30;
  localparam logic [3:0] IPC_CODE_ERASE = 4'h2;
  localparam logic [3:0] IPC_CODE_PROG = 4'h1;
  localparam logic [3:0] IPC_CODE_READ = 4'h0;

  // Data path widths and reset values of the plain byte registers
  localparam int IPC_ADDR_W = 16;
  localparam int IPC_DATA_W = 8;
  localparam logic [7:0] IPC_BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {IPC_OP_READ, IPC_OP_PROG, IPC_OP_ERASE} ipc_op_t;

  // Decode a command byte: bit 2 says the encoding is legal, bits 1:0 give the operation
  function automatic logic [2:0] ipc_decode(input logic [7:0] cmd);
    logic [2:0] res;
    res = 3'h0;
    if (!cmd[IPC_CMD_CE_BIT])
    begin
      if (cmd[3:0] == IPC_CODE_ERASE && cmd[IPC_CMD_OE_BIT])
        res = {1'b1, IPC_OP_ERASE};
      else if (cmd[3:0] == IPC_CODE_PROG && cmd[IPC_CMD_OE_BIT])
        res = {1'b1, IPC_OP_PROG};
      else if (cmd[3:0] == IPC_CODE_READ && !cmd[IPC_CMD_OE_BIT])
        res = {1'b1, IPC_OP_READ};
    end
    return res;
  endfunction : ipc_decode

endpackage : ipc_pkg

/* File: verilog/ipc_op_if.sv */
// Purpose: Operation request and answer between the control logic and the flash engine
// Assumes: One request outstanding at a time
// Notes: start is a one-cycle pulse; the other request fields stay stable while busy
interface ipc_op_if;
  import ipc_pkg::*;
  logic start;
  ipc_op_t op;
  logic bank;
  logic [IPC_ADDR_W-1:0] addr;
  logic [IPC_DATA_W-1:0] wdata;
  logic done;
  logic [IPC_DATA_W-1:0] rdata;
  logic busy;
  modport ctl (output start, op, bank, addr, wdata, input done, rdata, busy);
  modport eng (input start, op, bank, addr, wdata, output done, rdata, busy);
endinterface : ipc_op_if

/* File: verilog/ipc_flash_op.sv */
// Purpose: Drives one erase, program or read cycle on the flash array port
// Assumes: The array answers each held request with a one-cycle acknowledge
// Notes: All array outputs come from flip-flops
module ipc_flash_op
  import ipc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ipc_op_if.eng op_bus,
  output logic flash_req,
  output logic [1:0] flash_op,
  output logic flash_bank,
  output logic [IPC_ADDR_W-1:0] flash_addr,
  output logic [IPC_DATA_W-1:0] flash_wdata,
  input wire logic flash_ack,
  input wire logic [IPC_DATA_W-1:0] flash_rdata
);

  typedef enum logic {ENG_IDLE, ENG_WAIT} ipc_eng_t;
  ipc_eng_t state_reg;
  logic done_reg;
  logic [IPC_DATA_W-1:0] rdata_reg;

  // Request is latched so the array sees stable signals for the whole access
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ENG_IDLE;
      flash_req <= 1'b0;
      flash_op <= 2'h0;
      flash_bank <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= '0;
      done_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        ENG_IDLE:
        begin
          if (op_bus.start)
          begin
            state_reg <= ENG_WAIT;
            flash_req <= 1'b1;
            flash_op <= op_bus.op;
            flash_bank <= op_bus.bank;
            flash_addr <= op_bus.addr;
            flash_wdata <= op_bus.wdata;
          end
        end
        ENG_WAIT:
        begin
          if (flash_ack)
          begin
            state_reg <= ENG_IDLE;
            flash_req <= 1'b0;
            done_reg <= 1'b1;
            rdata_reg <= flash_rdata;
          end
        end
        default: state_reg <= ENG_IDLE;
      endcase
    end
  end

  // Answers back to the control logic
  assign op_bus.done = done_reg;
  assign op_bus.rdata = rdata_reg;
  assign op_bus.busy = (state_reg == ENG_WAIT);

endmodule : ipc_flash_op

/* File: verilog/ipc_isp_ctrl.sv */
// Purpose: In-system programming control: key unlock, mode entry on wake, flash commands
// Assumes: Register accesses arrive on the core's special-function-register bus
// Notes: Flash operations start only while the core sits in idle with programming mode on
module ipc_isp_ctrl
  import ipc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  input wire logic cpu_idle,
  output logic isp_mode,
  output logic exec_from_loader,
  output logic pc_clear,
  output logic cpu_reset_req,
  output logic aux_ram_en,
  output logic flash_busy,
  output logic flash_req,
  output logic [1:0] flash_op,
  output logic flash_bank,
  output logic [IPC_ADDR_W-1:0] flash_addr,
  output logic [IPC_DATA_W-1:0] flash_wdata,
  input wire logic flash_ack,
  input wire logic [IPC_DATA_W-1:0] flash_rdata
);

  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} ipc_key_t;

  ipc_key_t key_reg;
  ipc_key_t key_next;
  logic [7:0] ctrl_reg;
  logic [7:0] cmd_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] data_reg;
  logic cmd_pend_reg;
  logic start_reg;
  logic idle_d_reg;
  logic isp_mode_reg;
  logic exec_loader_reg;
  logic pc_clear_reg;
  logic sw_reset_reg;
  logic busy_reg;
  logic [7:0] rdata_reg;

  ipc_op_if op_bus ();

  // Internal reset: the software reset acts on every register the external one does, except its own pulse register
  wire blk_rst = rst | sw_reset_reg;

  // Address decode of the register bus
  wire wr_ctrl = sfr_we && (sfr_addr == IPC_ADDR_CTRL);
  wire wr_key = sfr_we && (sfr_addr == IPC_ADDR_KEY);
  wire wr_cmd = sfr_we && (sfr_addr == IPC_ADDR_CMD);
  wire wr_ahi = sfr_we && (sfr_addr == IPC_ADDR_AHI);
  wire wr_alo = sfr_we && (sfr_addr == IPC_ADDR_ALO);
  wire wr_dat = sfr_we && (sfr_addr == IPC_ADDR_DAT);

  // Control register writes only land once the key sequence has completed
  wire ctrl_open = (key_reg == KEY_OPEN);
  wire ctrl_take = wr_ctrl && ctrl_open;
  wire swr_hit = ctrl_take && ((sfr_wdata & IPC_CTRL_SWR_MASK) == IPC_CTRL_SWR_MASK);
  wire arm_bit = ctrl_reg[IPC_CTRL_ARM_BIT];
  wire loc_bit = ctrl_reg[IPC_CTRL_LOC_BIT];

  // Wake edge of the core
  wire wake = idle_d_reg && !cpu_idle;
  wire [2:0] dec = ipc_decode(cmd_reg);
  wire dec_ok = dec[2];
  wire [1:0] dec_op = dec[1:0];
  // Erase and program need the arm bit; read is always allowed in programming mode
  wire op_allowed = dec_ok && (arm_bit || (dec_op == IPC_OP_READ));
  // Command waits until both programming mode and idle hold
  wire can_launch = cmd_pend_reg && isp_mode_reg && cpu_idle && !busy_reg && !start_reg;
  wire launch = can_launch && op_allowed;
  // Idle outside programming mode drops a waiting command so it cannot fire on a later idle
  wire cmd_drop = cpu_idle && !isp_mode_reg;

  // Key sequence: 87h arms the first step, 59h right after opens, anything else closes
  always_comb
  begin
    key_next = key_reg;
    if (wr_key)
    begin
      if (sfr_wdata == IPC_KEY_FIRST)
        key_next = (key_reg == KEY_OPEN) ? KEY_OPEN : KEY_HALF;
      else if (sfr_wdata == IPC_KEY_SECOND && key_reg != KEY_LOCKED)
        key_next = KEY_OPEN;
      else
        key_next = KEY_LOCKED;
    end
  end

  // Key state and control register
  always_ff @(posedge clk)
  begin
    if (blk_rst)
    begin
      key_reg <= KEY_LOCKED;
      ctrl_reg <= IPC_CTRL_RESET;
    end
    else
    begin
      key_reg <= key_next;
      if (ctrl_take)
        ctrl_reg <= sfr_wdata & IPC_CTRL_WR_MASK;
    end
  end

  // Software reset pulse; cleared only by the external reset so it cannot hold itself
  always_ff @(posedge clk)
  begin
    if (rst)
      sw_reset_reg <= 1'b0;
    else
      sw_reset_reg <= swr_hit;
  end

  // Address, data and command registers
  always_ff @(posedge clk)
  begin
    if (blk_rst)
    begin
      addr_hi_reg <= IPC_BYTE_RESET;
      addr_lo_reg <= IPC_BYTE_RESET;
      data_reg <= IPC_BYTE_RESET;
      cmd_reg <= IPC_CMD_RESET;
      cmd_pend_reg <= 1'b0;
    end
    else
    begin
      if (wr_ahi)
        addr_hi_reg <= sfr_wdata;
      if (wr_alo)
        addr_lo_reg <= sfr_wdata;
      // Read results take priority; the core is idle when they arrive
      if (op_bus.done && (op_bus.op == IPC_OP_READ))
        data_reg <= op_bus.rdata;
      else if (wr_dat)
        data_reg <= sfr_wdata;
      if (wr_cmd)
        cmd_reg <= sfr_wdata & IPC_CMD_WR_MASK;
      // A new command write wins over the clear of the previous one
      if (wr_cmd)
        cmd_pend_reg <= 1'b1;
      else if (can_launch || cmd_drop)
        cmd_pend_reg <= 1'b0;
    end
  end

  // Mode entry happens only at the wake from idle; exit at the wake or on a software or external reset
  always_ff @(posedge clk)
  begin
    if (blk_rst)
    begin
      idle_d_reg <= 1'b0;
      isp_mode_reg <= 1'b0;
      exec_loader_reg <= 1'b0;
      pc_clear_reg <= 1'b0;
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      idle_d_reg <= cpu_idle;
      start_reg <= launch;
      busy_reg <= launch || start_reg || op_bus.busy;
      pc_clear_reg <= wake && arm_bit && loc_bit && !exec_loader_reg;
      if (wake)
      begin
        isp_mode_reg <= arm_bit;
        exec_loader_reg <= arm_bit && loc_bit;
      end
    end
  end

  // Request fields are stable registers while the engine works
  assign op_bus.start = start_reg;
  assign op_bus.op = ipc_op_t'(dec_op);
  assign op_bus.bank = cmd_reg[IPC_CMD_BANK_BIT];
  assign op_bus.addr = {addr_hi_reg, addr_lo_reg};
  assign op_bus.wdata = data_reg;

  ipc_flash_op u_eng (
    .clk(clk),
    .rst(blk_rst),
    .op_bus(op_bus),
    .flash_req(flash_req),
    .flash_op(flash_op),
    .flash_bank(flash_bank),
    .flash_addr(flash_addr),
    .flash_wdata(flash_wdata),
    .flash_ack(flash_ack),
    .flash_rdata(flash_rdata)
  );

  // Read mux; key register is write-only and unmapped addresses answer zero
  wire [7:0] rd_mux =
    (sfr_addr == IPC_ADDR_CTRL) ? ctrl_reg :
    (sfr_addr == IPC_ADDR_CMD) ? cmd_reg :
    (sfr_addr == IPC_ADDR_AHI) ? addr_hi_reg :
    (sfr_addr == IPC_ADDR_ALO) ? addr_lo_reg :
    (sfr_addr == IPC_ADDR_DAT) ? data_reg : IPC_BYTE_RESET;

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (blk_rst)
      rdata_reg <= IPC_BYTE_RESET;
    else if (sfr_re)
      rdata_reg <= rd_mux;
  end

  // Outputs straight from flip-flops
  assign sfr_rdata = rdata_reg;
  assign isp_mode = isp_mode_reg;
  assign exec_from_loader = exec_loader_reg;
  assign pc_clear = pc_clear_reg;
  assign cpu_reset_req = sw_reset_reg;
  assign aux_ram_en = ctrl_reg[IPC_CTRL_AUX_BIT];
  assign flash_busy = busy_reg;

endmodule : ipc_isp_ctrl

/* File: verif/ipc_isp_ctrl_checker.sv */
// Purpose: Timing checks on the programming control block ports
// Assumes: One clock, synchronous active-high reset
// Notes: Attached to the top module by bind
module ipc_isp_ctrl_checker
  import ipc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_rdata,
  input wire logic cpu_idle,
  input wire logic isp_mode,
  input wire logic exec_from_loader,
  input wire logic pc_clear,
  input wire logic cpu_reset_req,
  input wire logic flash_busy,
  input wire logic flash_req,
  input wire logic [1:0] flash_op,
  input wire logic flash_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Array traffic only inside a launched operation
  property p_req_busy; flash_req |-> flash_busy; endproperty
  a_req_busy: assert property (p_req_busy) else $error("request without busy");
  // Launch needs idle and programming mode, both seen at the launch edge
  property p_launch; $rose(flash_busy) |-> $past(cpu_idle) && $past(isp_mode); endproperty
  a_launch: assert property (p_launch) else $error("launch outside idle mode");
  property p_busy_req; $rose(flash_busy) |=> flash_req; endproperty
  a_busy_req: assert property (p_busy_req) else $error("request late after launch");
  property p_req_hold; flash_req && !flash_ack |=> flash_req && $stable(flash_op); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_ack_drop; flash_req && flash_ack |=> !flash_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  // Mode rises only one or two cycles after idle ends
  property p_mode_wake; $rose(isp_mode) |-> ($past(cpu_idle, 2) && !$past(cpu_idle)) ||
    ($past(cpu_idle, 3) && !$past(cpu_idle, 2)); endproperty
  a_mode_wake: assert property (p_mode_wake) else $error("mode entered without wake");
  property p_pc; pc_clear |-> exec_from_loader && isp_mode ##1 !pc_clear; endproperty
  a_pc: assert property (p_pc) else $error("bad counter clear pulse");
  property p_swr_trig; $rose(cpu_reset_req) |-> $past(sfr_we && sfr_addr == IPC_ADDR_CTRL &&
    sfr_wdata[7] && sfr_wdata[1:0] == 2'h3); endproperty
  a_swr_trig: assert property (p_swr_trig) else $error("reset without trigger");
  property p_swr; cpu_reset_req |=> !cpu_reset_req && !isp_mode && !exec_from_loader &&
    !flash_busy; endproperty
  a_swr: assert property (p_swr) else $error("software reset left state");
  property p_rsvd; sfr_re && sfr_addr == IPC_ADDR_CMD |=> !sfr_rdata[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved command bit set");
endmodule : ipc_isp_ctrl_checker

bind ipc_isp_ctrl ipc_isp_ctrl_checker chk (.*);

/* File: verif/ipc_flash_model.sv */
// Purpose: Behavioural flash array behind the programming control block
// Assumes: Erased bytes read as ff
// Notes: dly sets how many cycles a request waits for its acknowledge
module ipc_flash_model
  import ipc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic flash_req,
  input wire logic [1:0] flash_op,
  input wire logic flash_bank,
  input wire logic [IPC_ADDR_W-1:0] flash_addr,
  input wire logic [IPC_DATA_W-1:0] flash_wdata,
  input wire logic [3:0] dly,
  output logic flash_ack,
  output logic [IPC_DATA_W-1:0] flash_rdata
);
  logic [7:0] mem0 [logic [15:0]];
  logic [7:0] mem1 [logic [15:0]];
  logic [3:0] cnt;

  // Data lines toggle in every cycle except the ack cycle of a read so a stale byte never looks valid
  always @(posedge clk)
  begin
    flash_rdata <= rst ? 8'h3c : ~flash_rdata;
    flash_ack <= 1'b0;
    cnt <= 4'h0;
    if (!rst && flash_req && !flash_ack && cnt != dly)
      cnt <= cnt + 4'h1;
    else if (!rst && flash_req && !flash_ack)
    begin
      flash_ack <= 1'b1;
      if (flash_op == 2'h2 && flash_bank)
        mem1.delete();
      else if (flash_op == 2'h2)
        mem0.delete();
      else if (flash_op == 2'h1 && flash_bank)
        mem1[flash_addr] = flash_wdata;
      else if (flash_op == 2'h1)
        mem0[flash_addr] = flash_wdata;
      else if (flash_bank)
        flash_rdata <= mem1.exists(flash_addr) ? mem1[flash_addr] : 8'hff;
      else
        flash_rdata <= mem0.exists(flash_addr) ? mem0[flash_addr] : 8'hff;
    end
  end
endmodule : ipc_flash_model

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the programming control block
// Assumes: Flash array model answers every held request
// Notes: Inputs change on the falling clock edge
module tb
  import ipc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
  logic clk, rst = 1'b1, sfr_we = 1'b0, sfr_re = 1'b0, cpu_idle = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, flash_wdata, flash_rdata;
  logic isp_mode, exec_from_loader, pc_clear, cpu_reset_req, aux_ram_en, flash_busy;
  logic flash_req, flash_bank, flash_ack;
  logic [1:0] flash_op;
  logic [15:0] flash_addr;
  logic [3:0] dly = 4'h0;
  int err_count = 0, tests_run = 0, n_ops = 0, n_pc = 0, n_swr = 0;

  ipc_isp_ctrl dut (.*);
  ipc_flash_model fm (.*);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Count one-cycle events so short pulses are never missed
  always @(posedge clk)
  begin
    n_ops += (!rst && flash_req && flash_ack) ? 1 : 0;
    n_pc += (!rst && pc_clear) ? 1 : 0;
    n_swr += (!rst && cpu_reset_req) ? 1 : 0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    @(negedge clk);
    sfr_we = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_re = 1'b1;
    @(negedge clk);
    sfr_re = 1'b0;
    `CHK(sfr_rdata, e)
  endtask : rd

  task automatic unlock();
    wr(IPC_ADDR_KEY, IPC_KEY_FIRST);
    wr(IPC_ADDR_KEY, IPC_KEY_SECOND);
  endtask : unlock

  task automatic wake();
    @(negedge clk);
    cpu_idle = 1'b1;
    @(negedge clk);
    cpu_idle = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wake

  // Issue one command, stay idle until it is over, then wake
  task automatic op(input logic [7:0] c, input int go);
    int n0;
    int i;
    n0 = n_ops;
    wr(IPC_ADDR_CMD, c);
    `CHK(flash_busy, 1'b0)
    cpu_idle = 1'b1;
    repeat (6) @(negedge clk);
    for (i = 0; i < 40 && (n_ops < n0 + go || flash_busy !== 1'b0); i++)
      @(negedge clk);
    if (i == 40)
    begin
      err_count++;
      wrap_up();
    end
    `CHK(n_ops, n0 + go)
    cpu_idle = 1'b0;
    repeat (2) @(negedge clk);
  endtask : op

  task automatic s_reset();
    rd(IPC_ADDR_CTRL, 8'h00);
    rd(IPC_ADDR_CMD, 8'h30);
    rd(IPC_ADDR_KEY, 8'h00);
    rd(8'h80, 8'h00);
  endtask : s_reset

  // Wrong key order stays locked; a stray key value closes access again
  task automatic s_key();
    wr(IPC_ADDR_CTRL, 8'h01);
    rd(IPC_ADDR_CTRL, 8'h00);
    wr(IPC_ADDR_KEY, IPC_KEY_SECOND);
    wr(IPC_ADDR_KEY, IPC_KEY_FIRST);
    wr(IPC_ADDR_CTRL, 8'h01);
    rd(IPC_ADDR_CTRL, 8'h00);
    wr(IPC_ADDR_KEY, IPC_KEY_SECOND);
    wr(IPC_ADDR_CTRL, 8'h7f);
    rd(IPC_ADDR_CTRL, 8'h13);
    `CHK(aux_ram_en, 1'b1)
    wr(IPC_ADDR_KEY, 8'h00);
    wr(IPC_ADDR_CTRL, 8'h00);
    rd(IPC_ADDR_CTRL, 8'h13);
    unlock();
  endtask : s_key

  task automatic s_mode();
    wr(IPC_ADDR_CTRL, 8'h01);
    `CHK(isp_mode, 1'b0)
    wake();
    `CHK(isp_mode, 1'b1)
    `CHK(exec_from_loader, 1'b0)
    wr(IPC_ADDR_CTRL, 8'h00);
    op(8'h22, 0);
    `CHK(isp_mode, 1'b0)
    op(8'h00, 0);
  endtask : s_mode

  task automatic s_arm();
    wr(IPC_ADDR_CTRL, 8'h03);
    wake();
    `CHK(exec_from_loader, 1'b1)
    `CHK(n_pc, 1)
    // A read left waiting from outside programming mode must not launch now
    wake();
    `CHK(n_ops, 0)
  endtask : s_arm

  // Both banks, every operation code, slow and prompt array, bad encodings
  task automatic s_ops();
    wr(IPC_ADDR_AHI, 8'h12);
    wr(IPC_ADDR_ALO, 8'h34);
    wr(IPC_ADDR_DAT, 8'ha5);
    rd(IPC_ADDR_AHI, 8'h12);
    op(8'h21, 1);
    `CHK(flash_addr, 16'h1234)
    wr(IPC_ADDR_DAT, 8'h5a);
    dly = 4'h5;
    op(8'h61, 1);
    `CHK(flash_bank, 1'b1)
    op(8'h00, 1);
    rd(IPC_ADDR_DAT, 8'ha5);
    op(8'h40, 1);
    rd(IPC_ADDR_DAT, 8'h5a);
    op(8'h22, 1);
    `CHK(flash_op, 2'h2)
    op(8'h00, 1);
    rd(IPC_ADDR_DAT, 8'hff);
    op(8'h10, 0);
    op(8'h01, 0);
  endtask : s_ops

  task automatic s_swr();
    wr(IPC_ADDR_CTRL, 8'h83);
    @(negedge clk);
    `CHK(n_swr, 1)
    `CHK(isp_mode, 1'b0)
    `CHK(exec_from_loader, 1'b0)
    rd(IPC_ADDR_DAT, 8'h00);
    rd(IPC_ADDR_CMD, 8'h30);
    wr(IPC_ADDR_CTRL, 8'h03);
    rd(IPC_ADDR_CTRL, 8'h00);
    wr(IPC_ADDR_CMD, 8'hb0);
    rd(IPC_ADDR_CMD, 8'h30);
  endtask : s_swr

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    s_reset();
    s_key();
    s_mode();
    s_arm();
    s_ops();
    s_swr();
    wrap_up();
  end
endmodule : tb
